//--- alarm_event_capture_ctrl.sv
/*
  Two programmable alarms and the control that lets them trigger the
  dual-channel event capture, with the byte-wide register port.
  Assumes samples, sample_tick, capture_full and backup_valid come from logic
  on core_clk, and that the capture engine and flash store sit outside.
*/
`timescale 1ns/1ps
`include "alarm_capture_defs.svh"

// Behaviour
// - alarm_control bits 15:12 pick alarm two source; zero disables it.
// - alarm_control bits 11:8 pick alarm one source, same codes.
// - bit 6 set lets alarm two trigger capture.
// - bit 4 set lets alarm one trigger capture.
// - bit 2 enables the alarm indicator on an auxiliary line.
// - bit 1 set makes the indicator active high, clear active low.
// - bit 0 set puts indicator on line two, clear on line one.
// - writing 07 to byte 28 gives active-high indicator on line two.
// - threshold bit 15 set fires above threshold, clear fires below.
// - threshold bits 13:0 hold the level; bit 14 unused.
// - capture triggers come only from the two alarms.
// - recorded data source is chosen apart from the trigger source.
// - capture_setup upper byte picks sources for buffers two and one.
// - misc bit 11 saves full buffer to flash; restored after reset.
// - writing 03 to byte 3F clears buffer and flash copies.
// - command bits reset pointer, clear buffer, flash, full flag, save.
// - buffer length is a power of two, never below 3.
// - pretrigger length is cut to the buffer length when larger.
// - alarm flags stay until command bit 4; return if still true.
module alarm_event_capture_ctrl
(
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [5:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  input  wire logic                          sample_tick,
  input  wire alarm_capture_pkg::sample_set_t samples,
  input  wire logic                          capture_full,
  input  wire logic                          backup_valid,
  output logic                               aux_line_one_out,
  output logic                               aux_line_one_oe,
  output logic                               aux_line_two_out,
  output logic                               aux_line_two_oe,
  output logic                               capture_trigger,
  output alarm_capture_pkg::capture_cfg_t    capture_cfg,
  output alarm_capture_pkg::capture_data_t   capture_data,
  output alarm_capture_pkg::capture_cmd_t    capture_cmd
);

  // ==========================================================
  // helpers

  // picks the newest value of a source; unknown codes read as zero
  function automatic logic [13:0] pick_source
  (
    input logic [3:0]                    sel,
    input alarm_capture_pkg::sample_set_t s
  );
    logic [13:0] v;
    v = 14'h0000;
    case (sel)
      alarm_capture_pkg::SRC_SUPPLY: v = s.supply;
      alarm_capture_pkg::SRC_XACC:   v = s.xacc;
      alarm_capture_pkg::SRC_YACC:   v = s.yacc;
      alarm_capture_pkg::SRC_AUX:    v = s.aux;
      alarm_capture_pkg::SRC_TEMP:   v = s.temp;
      alarm_capture_pkg::SRC_RSS:    v = s.rss;
      default:                       v = 14'h0000;
    endcase
    return v;
  endfunction

  // ==========================================================
  // registers and state
  logic [15:0] alarm_control;
  logic [15:0] threshold [2];
  logic [15:0] capture_setup;
  logic [15:0] misc_control;
  logic [1:0]  alarm_live;
  logic [1:0]  alarm_flag;
  logic        full_seen;
  logic        restore_done;

  // ==========================================================
  // write decode
  wire wr_ctrl_lo  = reg_wr && (reg_addr == `ADDR_ALARM_CTRL_LO);
  wire wr_ctrl_hi  = reg_wr && (reg_addr == `ADDR_ALARM_CTRL_HI);
  wire wr_capt_lo  = reg_wr && (reg_addr == `ADDR_CAPT_LO);
  wire wr_capt_hi  = reg_wr && (reg_addr == `ADDR_CAPT_HI);
  wire wr_misc_hi  = reg_wr && (reg_addr == `ADDR_MISC_HI);
  wire wr_cmd_lo   = reg_wr && (reg_addr == `ADDR_COMMAND_LO);
  wire wr_cmd_hi   = reg_wr && (reg_addr == `ADDR_COMMAND_HI);

  // command byte viewed at its full 16-bit positions
  wire [15:0] cmd_word_hi = {reg_wdata, 8'h00};
  wire [15:0] cmd_word_lo = {8'h00, reg_wdata};

  wire clr_status = wr_cmd_lo && cmd_word_lo[`CMD_CLR_STATUS_BIT];

  // ==========================================================
  // configuration registers, byte writable
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_control <= `RST_ALARM_CTRL;
      capture_setup <= `RST_CAPT_SETUP;
      misc_control  <= `RST_MISC;
    end
    else
    begin
      // low byte write sets indicator and trigger arming
      if (wr_ctrl_lo)
        alarm_control[7:0] <= reg_wdata;
      if (wr_ctrl_hi)
        alarm_control[15:8] <= reg_wdata;
      if (wr_capt_lo)
        capture_setup[7:0] <= reg_wdata;
      // upper byte carries both recorded sources
      if (wr_capt_hi)
        capture_setup[15:8] <= reg_wdata;
      // only the autosave enable is held here; the low byte stays zero
      if (wr_misc_hi)
        misc_control[15:8] <= reg_wdata & 8'h08;
    end
  end

  // ==========================================================
  // per-alarm threshold, comparison and sticky flag
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : alarm_ch
      localparam logic [5:0] ADDR_LO = g ? `ADDR_ALARM_TWO_LO : `ADDR_ALARM_ONE_LO;
      localparam logic [5:0] ADDR_HI = g ? `ADDR_ALARM_TWO_HI : `ADDR_ALARM_ONE_HI;

      wire        wr_lo = reg_wr && (reg_addr == ADDR_LO);
      wire        wr_hi = reg_wr && (reg_addr == ADDR_HI);

      wire [3:0]  src = g ? alarm_control[`ACTL_SRC2_MSB:`ACTL_SRC2_LSB]
                          : alarm_control[`ACTL_SRC1_MSB:`ACTL_SRC1_LSB];
      wire [13:0] value = pick_source(src, samples);
      // level is bits 13:0 in the source format
      wire [13:0] level = threshold[g][`THR_LEVEL_MSB:0];
      // acceleration and temperature are two's complement, the rest unsigned
      wire        sgn   = (src == alarm_capture_pkg::SRC_XACC) || (src == alarm_capture_pkg::SRC_YACC) ||
                          (src == alarm_capture_pkg::SRC_TEMP);
      // a code outside the table acts like a disabled alarm
      wire        live  = ((src >= alarm_capture_pkg::SRC_SUPPLY) && (src <= alarm_capture_pkg::SRC_TEMP)) ||
                          (src == alarm_capture_pkg::SRC_RSS);
      wire        above = sgn ? ($signed(value) > $signed(level)) : (value > level);
      wire        below = sgn ? ($signed(value) < $signed(level)) : (value < level);
      // bit 15 picks greater-than or less-than
      wire        hit   = live &&
                          (threshold[g][`THR_DIR_BIT] ? above : below);

      // bit 14 is never stored so it always reads back zero
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          threshold[g] <= `RST_THRESHOLD;
        else
        begin
          if (wr_lo)
            threshold[g][7:0] <= reg_wdata;
          if (wr_hi)
            threshold[g][15:8] <= reg_wdata & 8'hBF;
        end
      end

      // compare once per sample with the newest value
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          alarm_live[g] <= 1'b0;
        else if (sample_tick)
          alarm_live[g] <= hit;
      end

      // a new hit wins over a clear in the same cycle
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          alarm_flag[g] <= 1'b0;
        else if (sample_tick && hit)
          alarm_flag[g] <= 1'b1;
        else if (clr_status)
          alarm_flag[g] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // capture trigger
  // alarm two arms the trigger only with bit 6
  wire arm_two = alarm_control[`ACTL_TRIG2_BIT];
  // alarm one arms the trigger only with bit 4
  wire arm_one = alarm_control[`ACTL_TRIG1_BIT];
  wire [1:0] hit_now = {alarm_ch[1].hit, alarm_ch[0].hit};
  // only a fresh alarm onset starts a capture
  wire trig_now = sample_tick &&
                  ((arm_two && hit_now[1] && !alarm_live[1]) ||
                   (arm_one && hit_now[0] && !alarm_live[0]));

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      capture_trigger <= 1'b0;
    else
      capture_trigger <= trig_now;
  end

  // ==========================================================
  // hardware alarm indicator
  // enable gates any drive of the lines
  wire ind_en   = alarm_control[`ACTL_IND_EN_BIT];
  wire ind_lvl  = alarm_control[`ACTL_IND_POL_BIT] ? |alarm_live : ~|alarm_live;
  wire ind_two  = alarm_control[`ACTL_IND_LINE_BIT];

  // the line is driven without checking its other uses
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aux_line_one_out <= 1'b0;
      aux_line_one_oe  <= 1'b0;
      aux_line_two_out <= 1'b0;
      aux_line_two_oe  <= 1'b0;
    end
    else
    begin
      aux_line_one_out <= ind_lvl;
      aux_line_one_oe  <= ind_en && !ind_two;
      aux_line_two_out <= ind_lvl;
      aux_line_two_oe  <= ind_en && ind_two;
    end
  end

  // ==========================================================
  // capture configuration and recorded data
  wire [3:0] len_raw = capture_setup[`CAPT_LEN_MSB:`CAPT_LEN_LSB];
  wire [3:0] pre_raw = capture_setup[`CAPT_PRE_MSB:`CAPT_PRE_LSB];
  // short settings are raised to the smallest length
  wire [3:0] len_eff = (len_raw < `CAPT_LEN_MIN) ? `CAPT_LEN_MIN : len_raw;
  // an over-long pretrigger becomes the whole buffer
  wire [3:0] pre_eff = (pre_raw > len_eff) ? len_eff : pre_raw;
  wire [3:0] rec_two = capture_setup[`CAPT_SRC2_MSB:`CAPT_SRC2_LSB];
  wire [3:0] rec_one = capture_setup[`CAPT_SRC1_MSB:`CAPT_SRC1_LSB];

  always_comb
  begin
    capture_cfg.src_two = rec_two;
    capture_cfg.src_one = rec_one;
    capture_cfg.pre_len = pre_eff;
    capture_cfg.buf_len = len_eff;
  end

  // recorded data follows capture_setup, not the alarm sources
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      capture_data <= '0;
    else
    begin
      capture_data.valid   <= sample_tick;
      capture_data.buf_one <= pick_source(rec_one, samples);
      capture_data.buf_two <= pick_source(rec_two, samples);
    end
  end

  // ==========================================================
  // capture commands and flash backup
  // autosave fires on the rising edge of the full flag
  wire autosave = misc_control[`MISC_AUTOSAVE_BIT] && capture_full && !full_seen;
  // restore once after reset while a backup is still held
  wire restore  = !restore_done && backup_valid;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      full_seen    <= 1'b0;
      restore_done <= 1'b0;
    end
    else
    begin
      full_seen    <= capture_full;
      restore_done <= 1'b1;
    end
  end

  // byte 3F value 03 raises both clear pulses together
  // each command bit of byte 3F yields a one-cycle pulse
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      capture_cmd <= '0;
    else
    begin
      capture_cmd.buf_clear     <= wr_cmd_hi && cmd_word_hi[`CMD_CLR_BUF_BIT];
      capture_cmd.flash_clear   <= wr_cmd_hi && cmd_word_hi[`CMD_CLR_FLASH_BIT];
      capture_cmd.ptr_reset     <= wr_cmd_hi && cmd_word_hi[`CMD_PTR_RESET_BIT];
      capture_cmd.full_clear    <= wr_cmd_hi && cmd_word_hi[`CMD_CLR_FULL_BIT];
      capture_cmd.flash_save    <= (wr_cmd_hi && cmd_word_hi[`CMD_SAVE_FLASH_BIT]) || autosave;
      capture_cmd.flash_restore <= restore;
    end
  end

  // ==========================================================
  // read path
  wire [15:0] status_word = ({15'h0000, capture_full} << `STAT_FULL_BIT) |
                            ({15'h0000, alarm_flag[1]} << `STAT_ALARM2_BIT) |
                            ({15'h0000, alarm_flag[0]} << `STAT_ALARM1_BIT);
  logic [7:0] next_rdata;

  // unmapped and write-only addresses read as zero
  always_comb
  begin
    if (reg_addr == `ADDR_ALARM_ONE_LO)
      next_rdata = threshold[0][7:0];
    else if (reg_addr == `ADDR_ALARM_ONE_HI)
      next_rdata = threshold[0][15:8];
    else if (reg_addr == `ADDR_ALARM_TWO_LO)
      next_rdata = threshold[1][7:0];
    else if (reg_addr == `ADDR_ALARM_TWO_HI)
      next_rdata = threshold[1][15:8];
    else if (reg_addr == `ADDR_ALARM_CTRL_LO)
      next_rdata = alarm_control[7:0];
    else if (reg_addr == `ADDR_ALARM_CTRL_HI)
      next_rdata = alarm_control[15:8];
    else if (reg_addr == `ADDR_MISC_LO)
      next_rdata = misc_control[7:0];
    else if (reg_addr == `ADDR_MISC_HI)
      next_rdata = misc_control[15:8];
    else if (reg_addr == `ADDR_CAPT_LO)
      next_rdata = capture_setup[7:0];
    else if (reg_addr == `ADDR_CAPT_HI)
      next_rdata = capture_setup[15:8];
    else if (reg_addr == `ADDR_STATUS_LO)
      next_rdata = status_word[7:0];
    else if (reg_addr == `ADDR_STATUS_HI)
      next_rdata = status_word[15:8];
    else
      next_rdata = 8'h00;
  end

  // read data holds until the next read strobe
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

endmodule

//--- alarm_capture_defs.svh
/*
  Register offsets, field positions and reset values of the alarm and
  event capture control block.
  Assumes byte addressing of 16-bit registers, low byte at the even address.
*/
`ifndef ALARM_CAPTURE_DEFS_SVH
`define ALARM_CAPTURE_DEFS_SVH

// ==========================================================
// byte addresses
`define ADDR_ALARM_ONE_LO    6'h20
`define ADDR_ALARM_ONE_HI    6'h21
`define ADDR_ALARM_TWO_LO    6'h22
`define ADDR_ALARM_TWO_HI    6'h23
`define ADDR_ALARM_CTRL_LO   6'h28
`define ADDR_ALARM_CTRL_HI   6'h29
`define ADDR_MISC_LO         6'h34
`define ADDR_MISC_HI         6'h35
`define ADDR_CAPT_LO         6'h38
`define ADDR_CAPT_HI         6'h39
`define ADDR_STATUS_LO       6'h3C
`define ADDR_STATUS_HI       6'h3D
`define ADDR_COMMAND_LO      6'h3E
`define ADDR_COMMAND_HI      6'h3F

// ==========================================================
// alarm_control fields
`define ACTL_SRC2_MSB        15
`define ACTL_SRC2_LSB        12
`define ACTL_SRC1_MSB        11
`define ACTL_SRC1_LSB        8
`define ACTL_TRIG2_BIT       6
`define ACTL_TRIG1_BIT       4
`define ACTL_IND_EN_BIT      2
`define ACTL_IND_POL_BIT     1
`define ACTL_IND_LINE_BIT    0

// threshold fields
`define THR_DIR_BIT          15
`define THR_LEVEL_MSB        13

// capture_setup fields
`define CAPT_SRC2_MSB        15
`define CAPT_SRC2_LSB        12
`define CAPT_SRC1_MSB        11
`define CAPT_SRC1_LSB        8
`define CAPT_PRE_MSB         7
`define CAPT_PRE_LSB         4
`define CAPT_LEN_MSB         3
`define CAPT_LEN_LSB         0
`define CAPT_LEN_MIN         4'h3

// misc_control, status and command fields
`define MISC_AUTOSAVE_BIT    11
`define STAT_FULL_BIT        12
`define STAT_ALARM2_BIT      9
`define STAT_ALARM1_BIT      8
`define CMD_CLR_STATUS_BIT   4
`define CMD_CLR_BUF_BIT      8
`define CMD_CLR_FLASH_BIT    9
`define CMD_PTR_RESET_BIT    10
`define CMD_SAVE_FLASH_BIT   11
`define CMD_CLR_FULL_BIT     12

// ==========================================================
// reset values
`define RST_ALARM_CTRL       16'h0000
`define RST_THRESHOLD        16'h0000
`define RST_CAPT_SETUP       16'h327A
`define RST_MISC             16'h0000

`endif

//--- alarm_capture_pkg.sv
/*
  Types shared by the alarm and event capture control block.
  Assumes the measurement path delivers 14-bit samples on the core clock.
*/
package alarm_capture_pkg;

  // ==========================================================
  // measurement source codes
  typedef enum logic [3:0] {
    SRC_OFF    = 4'h0,
    SRC_SUPPLY = 4'h1,
    SRC_XACC   = 4'h2,
    SRC_YACC   = 4'h3,
    SRC_AUX    = 4'h4,
    SRC_TEMP   = 4'h5,
    SRC_RSS    = 4'h8
  } source_sel_t;

  // newest value of every measurement
  typedef struct packed {
    logic [13:0] supply;
    logic [13:0] xacc;
    logic [13:0] yacc;
    logic [13:0] aux;
    logic [13:0] temp;
    logic [13:0] rss;
  } sample_set_t;

  // capture engine configuration
  typedef struct packed {
    logic [3:0] src_two;
    logic [3:0] src_one;
    logic [3:0] pre_len;
    logic [3:0] buf_len;
  } capture_cfg_t;

  // selected data to be recorded
  typedef struct packed {
    logic        valid;
    logic [13:0] buf_one;
    logic [13:0] buf_two;
  } capture_data_t;

  // one-cycle capture commands
  typedef struct packed {
    logic ptr_reset;
    logic buf_clear;
    logic flash_clear;
    logic full_clear;
    logic flash_save;
    logic flash_restore;
  } capture_cmd_t;

endpackage

//--- alarm_capture_monitor.sv
/*
  Port checker for the alarm and capture control block.
  Assumes it is bound onto alarm_event_capture_ctrl.
*/
`timescale 1ns/1ps
`include "alarm_capture_defs.svh"
module alarm_capture_monitor
(
  input wire logic                            core_clk,
  input wire logic                            nrst,
  input wire logic                            reg_wr,
  input wire logic                            reg_rd,
  input wire logic [5:0]                      reg_addr,
  input wire logic [7:0]                      reg_wdata,
  input wire logic [7:0]                      reg_rdata,
  input wire logic                            sample_tick,
  input wire alarm_capture_pkg::sample_set_t  samples,
  input wire logic                            aux_line_one_oe,
  input wire logic                            aux_line_two_oe,
  input wire logic                            capture_trigger,
  input wire alarm_capture_pkg::capture_cfg_t  capture_cfg,
  input wire alarm_capture_pkg::capture_data_t capture_data,
  input wire alarm_capture_pkg::capture_cmd_t  capture_cmd
);
  // ==========================================================
  // one clock domain, so a single default
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_one_line_only: assert property (!(aux_line_one_oe && aux_line_two_oe))
    else $error("both aux lines driven");
  a_trig_after_tick: assert property (capture_trigger |-> $past(sample_tick))
    else $error("trigger without sample");
  a_trig_one_cycle: assert property (capture_trigger |=> !capture_trigger)
    else $error("trigger longer than a cycle");
  a_buf_two_src: assert property (sample_tick && capture_cfg.src_two == 4'h2 |=>
    capture_data.valid && capture_data.buf_two == $past(samples.xacc))
    else $error("buffer two data wrong");
  a_len_floor: assert property (capture_cfg.buf_len >= 4'h3)
    else $error("buffer length below floor");
  a_pre_cut: assert property (capture_cfg.pre_len <= capture_cfg.buf_len)
    else $error("pretrigger above length");
  a_clear_cause: assert property (capture_cmd.buf_clear |->
    $past(reg_wr && reg_addr == `ADDR_COMMAND_HI && reg_wdata[0]))
    else $error("buffer clear without command");
  a_flash_clear: assert property (reg_wr && reg_addr == `ADDR_COMMAND_HI && reg_wdata[1]
    |=> capture_cmd.flash_clear)
    else $error("flash clear missing");
  a_restore_pulse: assert property (capture_cmd.flash_restore |=> !capture_cmd.flash_restore)
    else $error("restore longer than a cycle");
endmodule

//--- host_model.sv
/*
  Host side of the byte register port, with write and read tasks.
  Assumes requests launch on the falling edge of core_clk.
*/
`timescale 1ns/1ps
module host_model
(
  input  wire logic       core_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [5:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end

  // line kept free
  // this host never gives the aux lines other duties
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data shows no stale value
  endtask

  // data taken after the edge that sampled the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

//--- alarm_event_capture_ctrl_bench.sv
/*
  Self-checking bench for the alarm and capture control block.
  Assumes host_model drives the register port at the falling edge.
*/
`timescale 1ns/1ps
module alarm_event_capture_ctrl_bench;
  // ==========================================================
  // stimulus and observed ports
  logic                             core_clk = 1'b0;
  logic                             nrst = 1'b0;
  logic                             sample_tick = 1'b0;
  logic                             capture_full = 1'b0;
  logic                             backup_valid = 1'b0;
  alarm_capture_pkg::sample_set_t   samples = '0;
  wire logic                        reg_wr;
  wire logic                        reg_rd;
  wire logic [5:0]                  reg_addr;
  wire logic [7:0]                  reg_wdata;
  wire logic [7:0]                  reg_rdata;
  logic                             one_out;
  logic                             one_oe;
  logic                             two_out;
  logic                             two_oe;
  logic                             capture_trigger;
  alarm_capture_pkg::capture_cfg_t  capture_cfg;
  alarm_capture_pkg::capture_data_t capture_data;
  alarm_capture_pkg::capture_cmd_t  capture_cmd;
  int                               n_fail = 0;
  int                               n_compared = 0;
  int                               cyc = 0;
  int                               trig_n = 0;
  int                               cmd_n [6] = '{0, 0, 0, 0, 0, 0};
  logic [5:0]                       ra [9] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h28, 6'h29, 6'h38, 6'h39, 6'h10};
  logic [7:0]                       re [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7A, 8'h32, 8'h00};
  int                               ci [5] = '{4, 3, 5, 1, 2}; // command bit to struct bit

  always #10 core_clk = ~core_clk;

  host_model host_u (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  alarm_event_capture_ctrl dut_u (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_tick(sample_tick),
    .samples(samples), .capture_full(capture_full), .backup_valid(backup_valid),
    .aux_line_one_out(one_out), .aux_line_one_oe(one_oe), .aux_line_two_out(two_out),
    .aux_line_two_oe(two_oe), .capture_trigger(capture_trigger), .capture_cfg(capture_cfg),
    .capture_data(capture_data), .capture_cmd(capture_cmd));

  // pulses are counted so the exact landing cycle does not matter
  always @(posedge core_clk)
  begin
    cyc++;
    if (capture_trigger === 1'b1) trig_n++;
    for (int i = 0; i < 6; i++) if (capture_cmd[i] === 1'b1) cmd_n[i]++;
    if (cyc == 5000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic expect_reg(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk($sformatf("reg %h", a), 32'(d), 32'(e));
  endtask

  // one-cycle tick, then time for trigger and aux lines to land
  task automatic tick(input logic [13:0] x, input logic [13:0] y);
    @(negedge core_clk);
    samples.xacc = x;
    samples.yacc = y;
    sample_tick = 1'b1;
    @(negedge core_clk);
    sample_tick = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic give_verdict();
    $display("compared %0d wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial
  begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) nrst = 1'b1;
    for (int i = 0; i < 9; i++) expect_reg(ra[i], re[i]);
    chk("cfg", 32'(capture_cfg), 32'h327A);
    host_u.wr(6'h21, 8'hFF);
    expect_reg(6'h21, 8'hBF);
    $display("test reset values done");
    // alarm one above 100 on y, alarm two below 0 on x, line two high
    host_u.wr(6'h21, 8'h80);
    host_u.wr(6'h20, 8'h64);
    host_u.wr(6'h29, 8'h23);
    host_u.wr(6'h28, 8'h07);
    expect_reg(6'h28, 8'h07);
    host_u.wr(6'h28, 8'h57);
    tick(14'h0000, 14'h0032);
    chk("no trig", 32'(trig_n), 32'h0);
    tick(14'h0000, 14'h00C8);
    chk("trig one", 32'(trig_n), 32'h1);
    chk("line two", 32'({two_oe, two_out, one_oe}), 32'h6);
    expect_reg(6'h3D, 8'h01);
    tick(14'h3FFB, 14'h00C8);
    chk("trig two", 32'(trig_n), 32'h2);
    expect_reg(6'h3D, 8'h03);
    tick(14'h0000, 14'h0000);
    chk("idle high", 32'(two_out), 32'h0);
    expect_reg(6'h3D, 8'h03);
    host_u.wr(6'h3E, 8'h10);
    expect_reg(6'h3D, 8'h00);
    $display("test alarm trigger done");
    host_u.wr(6'h28, 8'h04);
    tick(14'h0000, 14'h00C8);
    chk("unarmed", 32'(trig_n), 32'h2);
    chk("line one low", 32'({one_oe, one_out, two_oe}), 32'h4);
    host_u.wr(6'h28, 8'h50);
    repeat (2) @(negedge core_clk);
    chk("no line", 32'({one_oe, two_oe}), 32'h0);
    $display("test indicator done");
    host_u.wr(6'h39, 8'h23);
    host_u.wr(6'h38, 8'h01);
    chk("cfg low", 32'(capture_cfg), 32'h2303);
    host_u.wr(6'h38, 8'hF4);
    chk("cfg pre", 32'(capture_cfg), 32'h2344);
    tick(14'h0123, 14'h0456);
    chk("data", 32'({capture_data.buf_two, capture_data.buf_one}), 32'h0048C456);
    $display("test capture data done");
    for (int i = 0; i < 5; i++)
    begin
      host_u.wr(6'h3F, 8'(1 << i));
      repeat (2) @(negedge core_clk);
      chk("cmd", 32'(cmd_n[ci[i]]), 32'h1);
    end
    host_u.wr(6'h3F, 8'h03);
    repeat (2) @(negedge core_clk);
    chk("clear both", 32'(cmd_n[4] + cmd_n[3]), 32'h4);
    $display("test commands done");
    host_u.wr(6'h35, 8'h08);
    host_u.wr(6'h34, 8'hFF);
    expect_reg(6'h35, 8'h08);
    expect_reg(6'h34, 8'h00);
    @(negedge core_clk) capture_full = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("autosave", 32'(cmd_n[1]), 32'h2);
    expect_reg(6'h3D, 8'h11);
    capture_full = 1'b0;
    backup_valid = 1'b1;
    @(negedge core_clk) nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("restore", 32'(cmd_n[0]), 32'h1);
    expect_reg(6'h29, 8'h00);
    $display("test backup done");
    give_verdict();
  end
endmodule

bind alarm_event_capture_ctrl alarm_capture_monitor mon_u (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sample_tick(sample_tick), .samples(samples), .aux_line_one_oe(aux_line_one_oe),
  .aux_line_two_oe(aux_line_two_oe), .capture_trigger(capture_trigger), .capture_cfg(capture_cfg),
  .capture_data(capture_data), .capture_cmd(capture_cmd));
